// ==== strap_mux_map.vh ====
`ifndef STRAP_MUX_MAP_VH
`define STRAP_MUX_MAP_VH

// Register byte offsets on the Wishbone slave.
`define REG_CTRL 8'h00
`define REG_RATE 8'h04
`define REG_STRAP 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_GENERAL 8'h14

// Strap bit positions on the shared pins.
`define STRAP_RATE_HI 2
`define STRAP_SELF_N 3
`define STRAP_TOEN_N 4
`define STRAP_TOSEL_N 5
`define STRAP_SOR_N 6
`define STRAP_IDLE_N 7

// Control field positions, same layout as status group 12.
`define CTRL_TOEN 0
`define CTRL_TOSEL_LO 1
`define CTRL_TOSEL_HI 3
`define CTRL_IDLE 4
`define CTRL_SOR 5
`define CTRL_SELF 6

// Interrupt event positions.
`define EV_LOADED 0
`define EV_TICK 1
`define EV_SELCHG 2

// Reset values.
`define CTRL_RESET 7'h00
`define GENERAL_RESET 8'h00
`define MASK_RESET 3'h0

// Timing: mclk period and timeout periods in nanoseconds.
`define CLK_PERIOD_NS 40
`define REF_PERIOD_NS 100
`define TO_SHORT_NS (200 * 4 * `REF_PERIOD_NS)
`define TO_LONG_NS (200 * 65536 * `REF_PERIOD_NS)
`define TO_SHORT_CYCLES (`TO_SHORT_NS / `CLK_PERIOD_NS)
`define TO_LONG_CYCLES (`TO_LONG_NS / `CLK_PERIOD_NS)

`endif

// ==== pin_sync.v ====
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter WIDTH = 8
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;

   // Two flops; only the second stage is visible outside.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stage1_q <= {WIDTH{1'b0}};
         stage2_q <= {WIDTH{1'b0}};
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule // pin_sync

`default_nettype wire

// ==== timeout_ticker.v ====
`timescale 1ns/10ps
`default_nettype none

module timeout_ticker #(
   parameter CW = 25,
   parameter SHORT_CYCLES = 2000,
   parameter LONG_CYCLES = 32768000
) (
   input wire mclk,
   input wire rst,
   input wire enable,
   input wire useShort,
   output reg tick
);

   reg [CW-1:0] count_q;
   reg shortSeen_q;
   wire [31:0] countWide;
   wire [31:0] limit;
   wire restart;

   assign countWide = {{(32-CW){1'b0}}, count_q};
   assign limit = useShort ? SHORT_CYCLES - 1 : LONG_CYCLES - 1;
   // A period change restarts the count so no stale long count leaks out.
   assign restart = !enable || (useShort != shortSeen_q);

   // Free count of whole periods; the tick is one cycle wide.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_q <= {CW{1'b0}};
         shortSeen_q <= 1'b0;
         tick <= 1'b0;
      end else begin
         shortSeen_q <= useShort;
         tick <= 1'b0;
         if (restart) begin
            count_q <= {CW{1'b0}};
         end else if (countWide >= limit) begin
            count_q <= {CW{1'b0}};
            tick <= 1'b1;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end

endmodule // timeout_ticker

`default_nettype wire

// ==== power_on_strap_status_mux.v ====
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "strap_mux_map.vh"

module power_on_strap_status_mux #(
   parameter LONG_TIMEOUT_CYCLES = `TO_LONG_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire wbCyc,
   input wire wbStb,
   input wire wbWe,
   input wire [7:0] wbAdr,
   input wire [3:0] wbSel,
   input wire [31:0] wbDatW,
   output reg [31:0] wbDatR,
   output reg wbAck,
   input wire [7:0] pinIn,
   output reg [7:0] pinOut,
   output reg [7:0] pinOe,
   input wire [3:0] statusSelect,
   input wire [2:0] clockMultiplierSelect,
   input wire [7:0] statusCfgPort,
   input wire [63:0] statusLinkPorts,
   input wire [15:0] statusExtPorts,
   input wire [7:0] statusDiscovery,
   input wire [7:0] statusErrorSummary,
   input wire [7:0] statusTimeCode,
   output reg [2:0] txRateCode,
   output reg [3:0] txRateDivisor,
   output reg [2:0] pllSelect,
   output reg selfAddrEn,
   output reg timeoutEn,
   output reg timeoutShort,
   output reg startOnReqEn,
   output reg idleShutdownEn,
   output reg strapsLoaded,
   output wire timeoutTick,
   output reg irq
);

   // Start-up sequence states.
   localparam [1:0] ST_SYNC1 = 2'b00;
   localparam [1:0] ST_SYNC2 = 2'b01;
   localparam [1:0] ST_LOAD = 2'b10;
   localparam [1:0] ST_RUN = 2'b11;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] strap_q;
   reg [6:0] ctrl_q;
   reg [7:0] general_q;
   reg [2:0] irqStat_q;
   reg [2:0] irqStat_d;
   reg [2:0] irqMask_q;
   reg [3:0] selPrev_q;
   reg loadPulse_q;
   reg [31:0] readData_d;
   reg [7:0] statusNext;
   wire [14:0] syncedPins;
   wire [7:0] strapSync;
   wire [2:0] multSync;
   wire [3:0] selSync;
   wire busReq;
   wire busWrite;
   wire [2:0] events;
   wire [2:0] w1cMask;
   wire [7:0] ctrlMerged;

   // Picks the low byte of a write word, honouring its lane select.
   function [7:0] laneMerge;
      input [7:0] oldVal;
      input [31:0] data;
      input [3:0] sel;
      begin
         laneMerge = sel[0] ? data[7:0] : oldVal;
      end
   endfunction

   // Status group decode; link and external groups are 8-bit slices.
   function [7:0] statusGroup;
      input [3:0] sel;
      input [7:0] cfg;
      input [63:0] links;
      input [15:0] ext;
      input [7:0] disc;
      input [7:0] ctrl;
      input [7:0] errs;
      input [7:0] tcode;
      input [7:0] gen;
      begin
         case (sel)
            4'h0: statusGroup = cfg;
            4'h1: statusGroup = links[7:0];
            4'h2: statusGroup = links[15:8];
            4'h3: statusGroup = links[23:16];
            4'h4: statusGroup = links[31:24];
            4'h5: statusGroup = links[39:32];
            4'h6: statusGroup = links[47:40];
            4'h7: statusGroup = links[55:48];
            4'h8: statusGroup = links[63:56];
            4'h9: statusGroup = ext[7:0];
            4'hA: statusGroup = ext[15:8];
            4'hB: statusGroup = disc;
            4'hC: statusGroup = ctrl;
            4'hD: statusGroup = errs;
            4'hE: statusGroup = tcode;
            4'hF: statusGroup = gen;
            default: statusGroup = 8'h00;
         endcase
      end
   endfunction

   // All pins cross into mclk through two flops before any logic.
   pin_sync #(
      .WIDTH(15)
   ) u_pinSync (
      .mclk(mclk),
      .rst(rst),
      .asyncIn({statusSelect, clockMultiplierSelect, pinIn}),
      .syncOut(syncedPins)
   );

   assign strapSync = syncedPins[7:0];
   assign multSync = syncedPins[10:8];
   assign selSync = syncedPins[14:11];

   // Period clock for port timeouts and silence detection.
   // period by strap
   timeout_ticker #(
      .CW(25),
      .SHORT_CYCLES(`TO_SHORT_CYCLES),
      .LONG_CYCLES(LONG_TIMEOUT_CYCLES)
   ) u_ticker (
      .mclk(mclk),
      .rst(rst),
      .enable(timeoutEn),
      .useShort(timeoutShort),
      .tick(timeoutTick)
   );

   // Start-up walks two sync cycles, one load cycle, then runs.
   // The board must hold straps through the load edge, which is
   // the third edge after release; pull resistors make that trivial.
   // hold window
   always @* begin
      case (state_q)
         ST_SYNC1: state_d = ST_SYNC2;
         ST_SYNC2: state_d = ST_LOAD;
         ST_LOAD: state_d = ST_RUN;
         ST_RUN: state_d = ST_RUN;
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_SYNC1;
      end else begin
         state_q <= state_d;
      end
   end

   // Pins are released as inputs under reset and until the load edge.
   // undriven until run
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinOe <= 8'h00;
      end else if (state_q == ST_LOAD) begin
         pinOe <= 8'hFF;
      end
   end

   // Straps and multiplier are snapshotted once, on the load edge only.
   // Anything seen on the pins later is our own drive and is ignored.
   // load once
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         strap_q <= 8'h00;
         pllSelect <= 3'h0;
         loadPulse_q <= 1'b0;
         strapsLoaded <= 1'b0;
      end else begin
         loadPulse_q <= (state_q == ST_LOAD);
         if (state_q == ST_LOAD) begin
            strap_q <= strapSync;
            pllSelect <= multSync;
            strapsLoaded <= 1'b1;
         end
      end
   end

   // Bus request qualifiers; the merged control byte is cut back to the
   // seven bits that exist, so bit 7 of a write is dropped on purpose.
   assign busReq = wbCyc && wbStb && !wbAck;
   assign busWrite = busReq && wbWe;
   assign ctrlMerged = laneMerge({1'b0, ctrl_q}, wbDatW, wbSel);

   // Control register: strap defaults at load, software edits after.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (state_q == ST_LOAD) begin
         ctrl_q[`CTRL_TOEN] <= !strapSync[`STRAP_TOEN_N];
         ctrl_q[`CTRL_TOSEL_HI:`CTRL_TOSEL_LO] <=
            {2'b00, strapSync[`STRAP_TOSEL_N]};
         ctrl_q[`CTRL_IDLE] <= !strapSync[`STRAP_IDLE_N];
         ctrl_q[`CTRL_SOR] <= !strapSync[`STRAP_SOR_N];
         ctrl_q[`CTRL_SELF] <= !strapSync[`STRAP_SELF_N];
      end else if (busWrite && wbAdr == `REG_CTRL) begin
         ctrl_q <= ctrlMerged[6:0];
      end
   end

   // Control fields fan out as registered configuration outputs.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         timeoutEn <= 1'b0;
         timeoutShort <= 1'b0;
         idleShutdownEn <= 1'b0;
         startOnReqEn <= 1'b0;
         selfAddrEn <= 1'b0;
      end else begin
         timeoutEn <= ctrl_q[`CTRL_TOEN];
         timeoutShort <= (ctrl_q[`CTRL_TOSEL_HI:`CTRL_TOSEL_LO] == 3'h1);
         idleShutdownEn <= ctrl_q[`CTRL_IDLE];
         startOnReqEn <= ctrl_q[`CTRL_SOR];
         selfAddrEn <= ctrl_q[`CTRL_SELF];
      end
   end

   // Link rate shared by all links: strapped, then overridable.
   // Divisor is 8 - code, so 111 runs at full and 000 at one eighth.
   // rate decode
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         txRateCode <= 3'h0;
         txRateDivisor <= 4'h8;
      end else if (state_q == ST_LOAD) begin
         txRateCode <= strapSync[`STRAP_RATE_HI:0];
         txRateDivisor <= 4'h8 - {1'b0, strapSync[`STRAP_RATE_HI:0]};
      end else if (busWrite && wbAdr == `REG_RATE && wbSel[0]) begin
         txRateCode <= wbDatW[2:0];
         txRateDivisor <= 4'h8 - {1'b0, wbDatW[2:0]};
      end
   end

   // General purpose byte shown on status group 15.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         general_q <= `GENERAL_RESET;
      end else if (busWrite && wbAdr == `REG_GENERAL) begin
         general_q <= laneMerge(general_q, wbDatW, wbSel);
      end
   end

   // Status byte is recomputed and registered on every edge, so the
   // pins settle one clock after the synchronised select changes.
   // group map
   always @* begin
      statusNext = statusGroup(selSync, statusCfgPort, statusLinkPorts,
         statusExtPorts, statusDiscovery, {1'b0, ctrl_q},
         statusErrorSummary, statusTimeCode, general_q);
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinOut <= 8'h00;
         selPrev_q <= 4'h0;
      end else begin
         pinOut <= statusNext;
         selPrev_q <= selSync;
      end
   end

   // Events: straps loaded, timeout period, status select moved.
   assign events[`EV_LOADED] = loadPulse_q;
   assign events[`EV_TICK] = timeoutTick;
   assign events[`EV_SELCHG] = (state_q == ST_RUN) && (selSync != selPrev_q);

   assign w1cMask = (busWrite && wbAdr == `REG_IRQ_STAT && wbSel[0]) ?
      wbDatW[2:0] : 3'h0;

   // Sticky status; a new event in the clearing cycle wins.
   always @* begin
      irqStat_d = (irqStat_q & ~w1cMask) | events;
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         irqStat_q <= 3'h0;
         irqMask_q <= `MASK_RESET;
         irq <= 1'b0;
      end else begin
         irqStat_q <= irqStat_d;
         if (busWrite && wbAdr == `REG_IRQ_MASK && wbSel[0]) begin
            irqMask_q <= wbDatW[2:0];
         end
         irq <= |(irqStat_d & irqMask_q);
      end
   end

   // Read decode; unmapped offsets read zero and still acknowledge.
   always @* begin
      readData_d = 32'h00000000;
      case (wbAdr)
         `REG_CTRL: readData_d[6:0] = ctrl_q;
         `REG_RATE: readData_d[6:0] = {pllSelect, 1'b0, txRateCode};
         `REG_STRAP: readData_d[8:0] = {strapsLoaded, strap_q};
         `REG_IRQ_STAT: readData_d[2:0] = irqStat_q;
         `REG_IRQ_MASK: readData_d[2:0] = irqMask_q;
         `REG_GENERAL: readData_d[7:0] = general_q;
         default: readData_d = 32'h00000000;
      endcase
   end

   // Classic Wishbone: ack one cycle after the request, for one cycle.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wbAck <= 1'b0;
         wbDatR <= 32'h00000000;
      end else begin
         wbAck <= busReq;
         if (busReq && !wbWe) begin
            wbDatR <= readData_d;
         end
      end
   end

endmodule // power_on_strap_status_mux

`default_nettype wire

// ==== strap_mux_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module strap_mux_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbAck,
   input wire logic [7:0] pinOe,
   input wire logic strapsLoaded,
   input wire logic [2:0] pllSelect,
   input wire logic timeoutEn,
   input wire logic timeoutTick,
   input wire logic irq
);
   logic [2:0] relCnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Edges since release; it saturates so a long run never wraps.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         relCnt <= 3'h0;
      else if (relCnt != 3'h7)
         relCnt <= relCnt + 3'h1;
   end
   // Pin drive, load, bus handshake and tick gating relations.
   a_oe_tracks_load: assert property (pinOe == {8{strapsLoaded}})
      else $error("pin enables out of step with load");
   a_quiet_first: assert property (relCnt < 3'h3 |-> pinOe == 8'h00)
      else $error("pins driven too early");
   a_drive_fourth: assert property (relCnt == 3'h3 |-> pinOe == 8'hFF)
      else $error("pins not driven in fourth cycle");
   a_load_sticky: assert property (strapsLoaded |=> strapsLoaded)
      else $error("load flag dropped");
   a_pll_frozen: assert property (strapsLoaded |=> $stable(pllSelect))
      else $error("multiplier changed after load");
   a_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
      else $error("ack without request");
   a_tick_gated: assert property (timeoutTick |-> timeoutEn || $past(timeoutEn))
      else $error("tick while timeouts off");
   c_drive: cover property ($rose(pinOe[0]));
   c_irq: cover property ($rose(irq));
   c_tick: cover property (timeoutTick);
endmodule // strap_mux_chk
`default_nettype wire

// ==== strap_board.sv ====
`timescale 1ns/10ps
`default_nettype none
module strap_board (
   input wire logic [7:0] strapLevel,
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   output wire logic [7:0] pinIn
);
   // resistor held straps
   // A driven pin overpowers its resistor; a released one falls back to it.
   assign pinIn = (pinOe & pinOut) | (~pinOe & strapLevel);
endmodule // strap_board
`default_nettype wire

// ==== power_on_strap_status_mux_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "strap_mux_map.vh"
module power_on_strap_status_mux_bench;
   localparam int LONG = 50;
   logic mclk, rst, wbCyc, wbStb, wbWe, wbAck, irq;
   logic [7:0] wbAdr, pinIn, pinOut, pinOe, strapLevel;
   logic [3:0] wbSel, statusSelect, txRateDivisor;
   logic [31:0] wbDatW, wbDatR, rd;
   logic selfAddrEn, timeoutEn, timeoutShort, timeoutTick;
   logic startOnReqEn, idleShutdownEn, strapsLoaded;
   logic [2:0] clockMultiplierSelect, txRateCode, pllSelect;
   logic [7:0] statusCfgPort, statusDiscovery, statusErrorSummary;
   logic [7:0] statusTimeCode;
   logic [63:0] statusLinkPorts;
   logic [15:0] statusExtPorts;
   int bad_count, tests_run;

   power_on_strap_status_mux #(.LONG_TIMEOUT_CYCLES(LONG)) i_dut (
      .mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
      .wbDatR(wbDatR), .wbAck(wbAck), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .statusSelect(statusSelect),
      .clockMultiplierSelect(clockMultiplierSelect),
      .statusCfgPort(statusCfgPort), .statusLinkPorts(statusLinkPorts),
      .statusExtPorts(statusExtPorts), .statusDiscovery(statusDiscovery),
      .statusErrorSummary(statusErrorSummary),
      .statusTimeCode(statusTimeCode), .txRateCode(txRateCode),
      .txRateDivisor(txRateDivisor), .pllSelect(pllSelect),
      .selfAddrEn(selfAddrEn), .timeoutEn(timeoutEn),
      .timeoutShort(timeoutShort), .startOnReqEn(startOnReqEn),
      .idleShutdownEn(idleShutdownEn), .strapsLoaded(strapsLoaded),
      .timeoutTick(timeoutTick), .irq(irq)
   );
   strap_board i_board (
      .strapLevel(strapLevel), .pinOut(pinOut), .pinOe(pinOe),
      .pinIn(pinIn)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic cmp(input logic [31:0] got, want, input string m);
      tests_run++;
      if (got !== want) begin
         bad_count++;
         $display("Error %0t: %s got %h want %h", $time, m, got, want);
      end
   endtask

   // One classic cycle; ack and read data are taken at one rising edge.
   // The wait is bounded so a dead slave cannot hang the run.
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      wbSel <= 4'h1;
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      cmp(n < 20, 1'b1, "bus ack");
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic power_up(input logic [7:0] s, input logic [2:0] m);
      @(posedge mclk);
      strapLevel <= s;
      clockMultiplierSelect <= m;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) begin
         @(negedge mclk);
         cmp(pinOe, 8'h00, "pins undriven");
      end
      @(negedge mclk);
      cmp(pinOe, 8'hFF, "pins driven");
      repeat (2) @(negedge mclk);
   endtask

   function automatic logic [7:0] grp(input int k, input logic [7:0] s);
      case (k)
         0: grp = statusCfgPort;
         9: grp = statusExtPorts[7:0];
         10: grp = statusExtPorts[15:8];
         11: grp = statusDiscovery;
         12: grp = {1'b0, ~s[3], ~s[6], ~s[7], 2'b00, s[5], ~s[4]};
         13: grp = statusErrorSummary;
         14: grp = statusTimeCode;
         15: grp = 8'h3C;
         default: grp = statusLinkPorts[(k-1)*8 +: 8];
      endcase
   endfunction

   task automatic t_load;
      logic [7:0] s;
      for (int i = 0; i < 8; i++) begin
         s = {i[2:0], i[1:0], i[2:0]};
         power_up(s, i[2:0]);
         cmp(txRateCode, s[2:0], "rate code");
         cmp(txRateDivisor, 4'h8 - s[2:0], "divisor");
         cmp(pllSelect, i[2:0], "multiplier");
         cmp({selfAddrEn, timeoutEn, timeoutShort, startOnReqEn,
              idleShutdownEn}, {~s[3], ~s[4], s[5], ~s[6], ~s[7]},
             "strap flags");
         wb(1'b0, `REG_STRAP, 32'h0, rd);
         cmp(rd, {23'h0, 1'b1, s}, "snapshot");
         wb(1'b0, `REG_RATE, 32'h0, rd);
         cmp(rd, {25'h0, i[2:0], 1'b0, s[2:0]}, "rate reg");
      end
   endtask

   task automatic t_mux;
      power_up(8'h26, 3'h1);
      wb(1'b1, `REG_GENERAL, 32'h3C, rd);
      for (int k = 0; k < 16; k++) begin
         @(posedge mclk);
         statusSelect <= k[3:0];
         repeat (4) @(negedge mclk);
         cmp(pinOut, grp(k, 8'h26), "mux out");
      end
      @(posedge mclk);
      statusSelect <= 4'h0;
      repeat (4) @(posedge mclk);
      statusCfgPort <= 8'h5A;
      repeat (2) @(negedge mclk);
      cmp(pinOut, 8'h5A, "refresh");
      wb(1'b0, `REG_STRAP, 32'h0, rd);
      cmp(rd, 32'h126, "straps ignored");
      wb(1'b0, 8'hFC, 32'h0, rd);
      cmp(rd, 32'h0, "unmapped");
      wb(1'b1, `REG_RATE, 32'h3, rd);
      repeat (2) @(negedge mclk);
      cmp({txRateCode, txRateDivisor}, 7'h35, "override");
   endtask

   task automatic t_irq;
      wb(1'b0, `REG_IRQ_STAT, 32'h0, rd);
      cmp({rd[0], irq}, 2'b10, "loaded, masked");
      wb(1'b1, `REG_IRQ_MASK, 32'h1, rd);
      repeat (2) @(negedge mclk);
      cmp(irq, 1'b1, "irq raised");
      wb(1'b1, `REG_IRQ_STAT, 32'h7, rd);
      repeat (2) @(negedge mclk);
      cmp(irq, 1'b0, "irq cleared");
      wb(1'b1, `REG_IRQ_MASK, 32'h4, rd);
      @(posedge mclk);
      statusSelect <= 4'h3;
      repeat (5) @(negedge mclk);
      cmp(irq, 1'b1, "select event");
      wb(1'b1, `REG_IRQ_MASK, 32'h0, rd);
   endtask

   task automatic tick_gap(output int n);
      int w;
      w = 0;
      n = 0;
      do begin
         @(negedge mclk);
         w++;
      end while (timeoutTick !== 1'b1 && w < 5000);
      do begin
         @(negedge mclk);
         n++;
      end while (timeoutTick !== 1'b1 && n < 5000);
   endtask

   task automatic t_tick;
      int n;
      wb(1'b1, `REG_CTRL, 32'h3, rd);
      tick_gap(n);
      cmp(n, 2000, "short period");
      wb(1'b1, `REG_CTRL, 32'h1, rd);
      tick_gap(n);
      cmp(n, LONG, "long period");
      wb(1'b1, `REG_CTRL, 32'h40, rd);
      n = 0;
      repeat (200) begin
         @(negedge mclk);
         n += timeoutTick;
      end
      cmp(n, 0, "ticks when off");
      cmp({selfAddrEn, timeoutEn, startOnReqEn}, 3'b100, "ctrl");
   endtask

   initial begin
      rst = 1'b1;
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
      strapLevel = 8'h00;
      statusSelect = 4'h0;
      clockMultiplierSelect = 3'h0;
      statusCfgPort = 8'hC1;
      statusLinkPorts = 64'h1817161514131211;
      statusExtPorts = 16'hE2E1;
      statusDiscovery = 8'hD4;
      statusErrorSummary = 8'hB3;
      statusTimeCode = 8'h7E;
      bad_count = 0;
      tests_run = 0;
      t_load;
      t_mux;
      t_irq;
      t_tick;
      final_report;
   end

   // The whole run needs well under 8000 cycles.
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      final_report;
   end

   task final_report;
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
endmodule // power_on_strap_status_mux_bench

bind power_on_strap_status_mux strap_mux_chk i_chk (
   .mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
   .wbAck(wbAck), .pinOe(pinOe), .strapsLoaded(strapsLoaded),
   .pllSelect(pllSelect), .timeoutEn(timeoutEn),
   .timeoutTick(timeoutTick), .irq(irq)
);
`default_nettype wire
